// >>> hw/prr_map.svh
// Constants of the return, rotate and prefetch execution block.
// Assumes inclusion by bare name from the exec module and the bench.
// Function
// - Prefetch opcode is one state and fills one aligned 32-byte operand cache block.
// - Prefetch block address is register n with its low five bits cleared.
// - Prefetch never raises an exception; a faulting prefetch acts as a no-op.
// - Rotate left through flag: shift left, old flag into bit 0, MSB to flag.
// - Rotate right through flag: shift right, old flag into bit 31, LSB to flag.
// - Plain rotate left: old MSB goes to bit 0 and to the flag.
// - Plain rotate right: old LSB goes to bit 31 and to the flag.
// - Exception return takes five states, restores status and PC from save copies.
// - Exception return in user mode raises illegal instruction instead.
// - Both returns are delayed: slot instruction runs before the target.
// - Interrupts are held off between a return and its slot instruction.
// - A branch in a return's delay slot raises slot illegal instruction.
// - Exception return inside another branch's delay slot raises slot illegal.
// - Slot fetched with old status; slot reads the restored status value.
// - Branch target is captured before the slot; slot writes cannot change it.
// - Subroutine return takes two states, loads PC from procedure return register.
// - No-operation only advances the PC, one state, no other change.
`ifndef PRR_MAP_SVH
`define PRR_MAP_SVH

`define PRR_OP_CACHE_PREFETCH 16'h0083
`define PRR_OP_ROT_LEFT_FLAG 16'h4024
`define PRR_OP_ROT_RIGHT_FLAG 16'h4025
`define PRR_OP_ROT_LEFT_PLAIN 16'h4004
`define PRR_OP_ROT_RIGHT_PLAIN 16'h4005
`define PRR_OP_EXCEPTION_RETURN 16'h002B
`define PRR_OP_SUB_RETURN 16'h000B
`define PRR_OP_NO_OPERATION 16'h0009
`define PRR_N_FIELD_MASK 16'hF0FF

`define PRR_EXC_RET_STATES 5
`define PRR_SUB_RET_STATES 2
`define PRR_PC_STEP 32'h0000_0002
`define PRR_BLOCK_MASK 32'hFFFF_FFE0
`define PRR_FLAG_BIT 0
`define PRR_PRIV_BIT 30

`define PRR_REG_CTRL 8'h00
`define PRR_REG_STATUS 8'h04
`define PRR_REG_TARGET 8'h08
`define PRR_CTRL_ENABLE_BIT 0
`define PRR_CTRL_RESET 1'b1
`define PRR_RESP_OKAY 2'h0
`define PRR_RESP_SLVERR 2'h2

`endif

// >>> hw/prr_pkg.sv
// Types of the return, rotate and prefetch execution block.
// Assumes the map header is on the include path.
package prr_pkg;
	typedef enum logic [1:0] {
		PRR_IDLE = 2'h0,
		PRR_BUSY = 2'h1,
		PRR_SLOT = 2'h3
	} prr_state_t;

	typedef struct packed {
		logic we;
		logic [3:0] addr;
		logic [31:0] data;
	} prr_wr_t;
endpackage

// >>> hw/prr_exec.sv
// Executes prefetch, four one-bit rotates, both delayed returns and no-op.
// Assumes a register file read port on the n field of the offered opcode,
// and status / save registers that update at the edge after a write pulse.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "prr_map.svh"
module prr_exec
	import prr_pkg::*;
#(
	parameter int EXC_RET_STATES = `PRR_EXC_RET_STATES,
	parameter int SUB_RET_STATES = `PRR_SUB_RET_STATES
)(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Instruction stream
	input wire logic insn_valid,
	input wire logic [15:0] insn_code,
	input wire logic [31:0] insn_pc,
	input wire logic insn_is_branch,
	input wire logic insn_in_slot,
	output logic insn_ready_ff,
	// Register file and control registers
	input wire logic [31:0] reg_n_value,
	input wire logic [31:0] status_in,
	input wire logic [31:0] saved_status,
	input wire logic [31:0] saved_pc,
	input wire logic [31:0] proc_ret,
	output prr_wr_t rf_wr_ff,
	output logic status_we_ff,
	output logic [31:0] status_data_ff,
	output logic [31:0] pc_ff,
	output logic pc_load_ff,
	output logic int_hold_ff,
	// Operand cache
	output logic prefetch_req_ff,
	output logic [31:0] prefetch_addr_ff,
	// Exceptions
	output logic exc_illegal_ff,
	output logic exc_slot_illegal_ff,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	function automatic logic match_n(input logic [15:0] code, input logic [15:0] op);
		match_n = (code & `PRR_N_FIELD_MASK) == op;
	endfunction

	prr_state_t state_ff, nxt_state;
	logic [2:0] cnt_ff, nxt_cnt;
	logic [31:0] target_ff;
	logic exc_ret_ff;
	logic enable_ff;
	logic aw_got_ff, w_got_ff, wstb_ff;
	logic [7:0] waddr_ff;
	logic [31:0] wdat_ff;
	logic [31:0] rd_mux;
	logic [1:0] rd_resp;

	// Decode on forwarded operands: file and status land one edge after our write
	wire [31:0] rn_cur = (rf_wr_ff.we && rf_wr_ff.addr == insn_code[11:8]) ? rf_wr_ff.data : reg_n_value;
	wire [31:0] st_cur = status_we_ff ? status_data_ff : status_in;
	wire t_in = st_cur[`PRR_FLAG_BIT];
	wire priv = st_cur[`PRR_PRIV_BIT];
	wire rn_msb = rn_cur[31];
	wire rn_lsb = rn_cur[0];
	wire dec_pf = match_n(insn_code, `PRR_OP_CACHE_PREFETCH);
	wire dec_lt = match_n(insn_code, `PRR_OP_ROT_LEFT_FLAG);
	wire dec_rt = match_n(insn_code, `PRR_OP_ROT_RIGHT_FLAG);
	wire dec_l = match_n(insn_code, `PRR_OP_ROT_LEFT_PLAIN);
	wire dec_r = match_n(insn_code, `PRR_OP_ROT_RIGHT_PLAIN);
	wire dec_xr = insn_code == `PRR_OP_EXCEPTION_RETURN;
	wire dec_sub = insn_code == `PRR_OP_SUB_RETURN;
	wire dec_noop = insn_code == `PRR_OP_NO_OPERATION;
	wire dec_rot = dec_lt | dec_rt | dec_l | dec_r;
	wire dec_step = dec_pf | dec_rot | dec_noop;

	wire acc = insn_valid & insn_ready_ff;
	wire in_slot = state_ff == PRR_SLOT;
	// Slot of our own return: any branch there is refused
	wire slot_bad = in_slot & (insn_is_branch | dec_xr | dec_sub);
	// Exception return inside a foreign branch's slot
	wire nested_bad = !in_slot & insn_in_slot & dec_xr;
	wire user_bad = !in_slot & !insn_in_slot & dec_xr & !priv;
	wire go_xr = acc & !in_slot & !insn_in_slot & dec_xr & priv;
	wire go_sub = acc & !in_slot & !insn_in_slot & dec_sub;
	// Prefetch has no exception term at all; cache drops faulting fills
	wire do_step = acc & dec_step & !slot_bad;
	wire busy_last = state_ff == PRR_BUSY && cnt_ff == 3'h1;

	// Rotate results, flag always the bit shifted out
	wire [31:0] rot_val = dec_lt ? {rn_cur[30:0], t_in} :
		dec_rt ? {t_in, rn_cur[31:1]} :
		dec_l ? {rn_cur[30:0], rn_msb} :
		{rn_lsb, rn_cur[31:1]};
	wire rot_flag = (dec_lt | dec_l) ? rn_msb : rn_lsb;

	// Sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			PRR_IDLE: begin
				if (go_xr) begin
					nxt_state = PRR_BUSY;
					nxt_cnt = 3'(EXC_RET_STATES - 1);
				end else if (go_sub) begin
					nxt_state = PRR_BUSY;
					nxt_cnt = 3'(SUB_RET_STATES - 1);
				end
			end
			PRR_BUSY: begin
				nxt_cnt = cnt_ff - 3'h1;
				if (cnt_ff == 3'h1) begin
					nxt_state = PRR_SLOT;
				end
			end
			PRR_SLOT: begin
				if (acc) begin
					nxt_state = PRR_IDLE;
				end
			end
			default: nxt_state = PRR_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= PRR_IDLE;
			cnt_ff <= 3'h0;
			insn_ready_ff <= 1'b0;
			int_hold_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			// Slot fetch waits until the return has used all its states
			insn_ready_ff <= enable_ff && nxt_state != PRR_BUSY;
			int_hold_ff <= nxt_state != PRR_IDLE;
		end
	end

	// Target is latched at the return itself, so a slot write to
	// the source register cannot redirect the branch
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			target_ff <= 32'h0000_0000;
			exc_ret_ff <= 1'b0;
		end else if (go_xr) begin
			target_ff <= saved_pc;
			exc_ret_ff <= 1'b1;
		end else if (go_sub) begin
			target_ff <= proc_ret;
			exc_ret_ff <= 1'b0;
		end
	end

	// Register, status and cache effects
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rf_wr_ff <= '0;
			status_we_ff <= 1'b0;
			status_data_ff <= 32'h0000_0000;
			prefetch_req_ff <= 1'b0;
			prefetch_addr_ff <= 32'h0000_0000;
		end else begin
			rf_wr_ff.we <= do_step & dec_rot;
			rf_wr_ff.addr <= insn_code[11:8];
			rf_wr_ff.data <= rot_val;
			// Restored status lands before the slot executes
			status_we_ff <= (do_step & dec_rot) | (busy_last & exc_ret_ff);
			if (busy_last & exc_ret_ff) begin
				status_data_ff <= saved_status;
			end else begin
				status_data_ff <= {st_cur[31:1], rot_flag};
			end
			prefetch_req_ff <= do_step & dec_pf;
			prefetch_addr_ff <= rn_cur & `PRR_BLOCK_MASK;
		end
	end

	// Program counter and exceptions
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pc_ff <= 32'h0000_0000;
			pc_load_ff <= 1'b0;
			exc_illegal_ff <= 1'b0;
			exc_slot_illegal_ff <= 1'b0;
		end else begin
			pc_load_ff <= acc & in_slot & !slot_bad;
			if (acc & in_slot & !slot_bad) begin
				pc_ff <= target_ff;
			end else if (do_step) begin
				pc_ff <= insn_pc + `PRR_PC_STEP;
			end
			exc_illegal_ff <= acc & user_bad;
			exc_slot_illegal_ff <= acc & (slot_bad | nested_bad);
		end
	end

	// AXI4-Lite write side: address and data in either order
	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire wr_fire = aw_got_ff & w_got_ff & !s_axi_bvalid;
	wire nxt_aw_got = aw_hs | (aw_got_ff & !wr_fire);
	wire nxt_w_got = w_hs | (w_got_ff & !wr_fire);
	wire wr_ctrl = waddr_ff == `PRR_REG_CTRL;
	wire wr_known = wr_ctrl || waddr_ff == `PRR_REG_STATUS || waddr_ff == `PRR_REG_TARGET;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			waddr_ff <= 8'h00;
			wdat_ff <= 32'h0000_0000;
			wstb_ff <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			aw_got_ff <= nxt_aw_got;
			w_got_ff <= nxt_w_got;
			s_axi_awready <= !nxt_aw_got;
			s_axi_wready <= !nxt_w_got;
			if (aw_hs) begin
				waddr_ff <= s_axi_awaddr;
			end
			if (w_hs) begin
				wdat_ff <= s_axi_wdata;
				wstb_ff <= s_axi_wstrb[0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PRR_RESP_OKAY;
			enable_ff <= `PRR_CTRL_RESET;
		end else begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? `PRR_RESP_OKAY : `PRR_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// Clearing enable stalls the stream after the current step
			if (wr_fire && wr_ctrl && wstb_ff) begin
				enable_ff <= wdat_ff[`PRR_CTRL_ENABLE_BIT];
			end
		end
	end

	// AXI4-Lite read side
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_resp = `PRR_RESP_OKAY;
		if (s_axi_araddr == `PRR_REG_CTRL) begin
			rd_mux[`PRR_CTRL_ENABLE_BIT] = enable_ff;
		end else if (s_axi_araddr == `PRR_REG_STATUS) begin
			rd_mux[3:0] = {int_hold_ff, exc_ret_ff, state_ff};
		end else if (s_axi_araddr == `PRR_REG_TARGET) begin
			rd_mux = target_ff;
		end else begin
			rd_resp = `PRR_RESP_SLVERR;
		end
	end

	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire nxt_rvalid = ar_hs | (s_axi_rvalid & !s_axi_rready);

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `PRR_RESP_OKAY;
		end else begin
			s_axi_rvalid <= nxt_rvalid;
			s_axi_arready <= !nxt_rvalid;
			if (ar_hs) begin
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_resp;
			end
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	wire [26:0] rn_hi = rn_cur[31:5];
	sequence s_xr_stall;
		(!insn_ready_ff)[*4];
	endsequence
	sequence s_slot_open;
		in_slot && int_hold_ff;
	endsequence

	cache_prefetch_block_addr_a: assert property (acc && dec_pf && !slot_bad |=>
		prefetch_req_ff && prefetch_addr_ff[31:5] == $past(rn_hi) && prefetch_addr_ff[4:0] == 5'h00)
		else $error("prefetch address not block aligned");
	rot_flag_left_a: assert property (acc && dec_lt && !slot_bad |=>
		rf_wr_ff.data[0] == $past(t_in) && status_data_ff[0] == $past(rn_msb))
		else $error("rotate left through flag wrong");
	rot_flag_right_a: assert property (acc && dec_rt && !slot_bad |=>
		rf_wr_ff.data[31] == $past(t_in) && status_data_ff[0] == $past(rn_lsb))
		else $error("rotate right through flag wrong");
	rot_plain_left_a: assert property (acc && dec_l && !slot_bad |=>
		rf_wr_ff.data[0] == $past(rn_msb) && status_data_ff[0] == rf_wr_ff.data[0])
		else $error("plain rotate left wrong");
	rot_plain_right_a: assert property (acc && dec_r && !slot_bad |=>
		rf_wr_ff.data[31] == $past(rn_lsb) && status_data_ff[0] == rf_wr_ff.data[31])
		else $error("plain rotate right wrong");
	xr_five_states_a: assert property (go_xr && EXC_RET_STATES == 5 |=>
		s_xr_stall ##1 s_slot_open)
		else $error("exception return state count wrong");
	xr_user_mode_a: assert property (acc && user_bad |=>
		exc_illegal_ff && !pc_load_ff ##1 state_ff == PRR_IDLE)
		else $error("user mode exception return not refused");
	slot_branch_a: assert property (acc && slot_bad |=>
		exc_slot_illegal_ff && !pc_load_ff)
		else $error("branch in return slot not refused");
	target_held_a: assert property (pc_load_ff |-> pc_ff == $past(target_ff, 2))
		else $error("branch target changed after capture");
	hold_slot_a: assert property (go_sub |=> int_hold_ff ##1 s_slot_open)
		else $error("interrupt hold or two-state return wrong");

endmodule
`default_nettype wire

// >>> sim/prr_core_model.sv
// Register file and status register standing behind the exec block.
// Assumes save copies and procedure return are driven by the bench.
`timescale 1ns/1ps
`default_nettype none
module prr_core_model
	import prr_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Exec block side
	input wire logic [15:0] insn_code,
	input wire prr_wr_t rf_wr,
	input wire logic status_we,
	input wire logic [31:0] status_data,
	output logic [31:0] reg_n_value,
	output logic [31:0] status_in
);
	logic [31:0] regs_ff [16];

	assign reg_n_value = regs_ff[insn_code[11:8]];

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 16; i++) begin
				regs_ff[i] <= 32'h8765_4321 ^ {i[3:0], 28'h0};
			end
			status_in <= 32'h4000_0000;
		end else begin
			if (rf_wr.we) begin
				regs_ff[rf_wr.addr] <= rf_wr.data;
			end
			// Lands at the edge after the pulse; the exec block forwards it meanwhile
			if (status_we) begin
				status_in <= status_data;
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/prefetch_rotate_return_exec_bench.sv
// Self-checking bench for the prefetch, rotate and return execution block.
// Assumes the core model supplies register n and status; save copies come from here.
`timescale 1ns/1ps
`default_nettype none
`include "prr_map.svh"
module prefetch_rotate_return_exec_bench
	import prr_pkg::*;
;
	logic clk_sys, reset_n, insn_valid, insn_is_branch, insn_in_slot;
	logic [15:0] insn_code;
	logic [31:0] insn_pc, saved_status, saved_pc, proc_ret, pc, s_axi_wdata;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire logic insn_ready_ff, status_we_ff, pc_load_ff, int_hold_ff, prefetch_req_ff;
	wire logic exc_illegal_ff, exc_slot_illegal_ff;
	wire logic [31:0] reg_n_value, status_in, status_data_ff, pc_ff, prefetch_addr_ff, s_axi_rdata;
	wire prr_wr_t rf_wr_ff;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] exp_reg [16];
	logic exp_t;
	int n_fail, compares;
	int cycles = 0;

	prr_exec dut_u (
		.clk_sys(clk_sys), .reset_n(reset_n), .insn_valid(insn_valid), .insn_code(insn_code),
		.insn_pc(insn_pc), .insn_is_branch(insn_is_branch), .insn_in_slot(insn_in_slot),
		.insn_ready_ff(insn_ready_ff), .reg_n_value(reg_n_value), .status_in(status_in),
		.saved_status(saved_status), .saved_pc(saved_pc), .proc_ret(proc_ret), .rf_wr_ff(rf_wr_ff),
		.status_we_ff(status_we_ff), .status_data_ff(status_data_ff), .pc_ff(pc_ff),
		.pc_load_ff(pc_load_ff), .int_hold_ff(int_hold_ff), .prefetch_req_ff(prefetch_req_ff),
		.prefetch_addr_ff(prefetch_addr_ff), .exc_illegal_ff(exc_illegal_ff),
		.exc_slot_illegal_ff(exc_slot_illegal_ff), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready)
	);

	prr_core_model model_u (
		.clk_sys(clk_sys), .reset_n(reset_n), .insn_code(insn_code), .rf_wr(rf_wr_ff),
		.status_we(status_we_ff), .status_data(status_data_ff), .reg_n_value(reg_n_value),
		.status_in(status_in)
	);

	task automatic report_and_stop();
		$display("Mismatches %0d of %0d comparisons", n_fail, compares);
		if (n_fail == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] want);
		compares++;
		if (got !== want) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	task automatic step();
		@(posedge clk_sys);
		#1;
	endtask

	// Offer one opcode and hold it until taken; wt counts edges waited
	task automatic issue(input logic [15:0] c, input logic br, input logic sl, output int wt);
		insn_code <= c;
		insn_pc <= pc;
		insn_is_branch <= br;
		insn_in_slot <= sl;
		insn_valid <= 1'h1;
		wt = 0;
		do begin
			@(posedge clk_sys);
			wt++;
		end while (!insn_ready_ff && wt < 50);
		insn_valid <= 1'h0;
		// Effects are one-cycle pulses: look just after the taking edge
		#1;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid && n < 100);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
		#1;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid && n < 100);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
		#1;
	endtask

	function automatic logic [15:0] rot_code(input int k);
		case (k)
			0: rot_code = `PRR_OP_ROT_LEFT_FLAG;
			1: rot_code = `PRR_OP_ROT_RIGHT_FLAG;
			2: rot_code = `PRR_OP_ROT_LEFT_PLAIN;
			default: rot_code = `PRR_OP_ROT_RIGHT_PLAIN;
		endcase
	endfunction

	// Returns {new flag, new value}
	function automatic logic [32:0] rot(input int k, input logic [31:0] v, input logic t);
		case (k)
			0: rot = {v[31], v[30:0], t};
			1: rot = {v[0], t, v[31:1]};
			2: rot = {v[31], v[30:0], v[31]};
			default: rot = {v[0], v[0], v[31:1]};
		endcase
	endfunction

	task automatic do_rot(input int k, input int n, output int wt);
		logic [32:0] r;
		r = rot(k, exp_reg[n], exp_t);
		issue(rot_code(k) | (16'(n) << 8), 1'h0, 1'h0, wt);
		chk({rf_wr_ff.we, status_we_ff, rf_wr_ff.addr}, {2'h3, 4'(n)});
		chk(rf_wr_ff.data, r[31:0]);
		chk(status_data_ff[0], r[32]);
		exp_reg[n] = r[31:0];
		exp_t = r[32];
	endtask

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(8'h00, d, r);
		chk({r, d}, {`PRR_RESP_OKAY, 32'h1});
		axi_wr(8'h00, 32'h0, r);
		step();
		chk(insn_ready_ff, 1'h0);
		axi_wr(8'h00, 32'h1, r);
		step();
		chk(insn_ready_ff, 1'h1);
		axi_rd(8'h04, d, r);
		chk(d, 32'h0);
		axi_rd(8'h10, d, r);
		chk({r, d}, {`PRR_RESP_SLVERR, 32'h0});
		axi_wr(8'h0C, 32'h5, r);
		chk(r, `PRR_RESP_SLVERR);
	endtask

	task automatic t_rot_cache_prefetch_nop();
		int wt;
		for (int i = 0; i < 8; i++) begin
			do_rot(i % 4, i + 1, wt);
			chk(pc_ff, pc + 32'h2);
			pc += 32'h2;
		end
		issue(`PRR_OP_CACHE_PREFETCH | 16'h0600, 1'h0, 1'h0, wt);
		chk(prefetch_req_ff, 1'h1);
		chk(prefetch_addr_ff, exp_reg[6] & ~32'h1F);
		chk({exc_illegal_ff, exc_slot_illegal_ff, rf_wr_ff.we}, 32'h0);
		chk(pc_ff, pc + 32'h2);
		pc += 32'h2;
		issue(`PRR_OP_NO_OPERATION, 1'h0, 1'h0, wt);
		chk({rf_wr_ff.we, status_we_ff, pc_load_ff, prefetch_req_ff}, 32'h0);
		chk(pc_ff, pc + 32'h2);
		pc += 32'h2;
	endtask

	task automatic t_rte(input logic [31:0] ss);
		int wt;
		saved_status <= ss;
		saved_pc <= 32'h0000_8000;
		issue(`PRR_OP_EXCEPTION_RETURN, 1'h0, 1'h0, wt);
		chk({int_hold_ff, pc_load_ff}, 32'h2);
		saved_pc <= 32'h0000_9000;
		exp_t = ss[0];
		do_rot(0, 1, wt);
		chk(32'(wt), 32'(`PRR_EXC_RET_STATES));
		chk(status_data_ff[31:1], ss[31:1]);
		chk({pc_load_ff, int_hold_ff}, 32'h2);
		chk(pc_ff, 32'h0000_8000);
		pc = 32'h0000_8000;
	endtask

	task automatic t_rts_slots();
		int wt;
		proc_ret <= 32'h0000_4400;
		issue(`PRR_OP_SUB_RETURN, 1'h0, 1'h0, wt);
		chk(int_hold_ff, 1'h1);
		do_rot(1, 2, wt);
		chk(32'(wt), 32'(`PRR_SUB_RET_STATES));
		chk({pc_load_ff, pc_ff}, {1'h1, 32'h0000_4400});
		pc = 32'h0000_4400;
		for (int i = 0; i < 2; i++) begin
			issue(i ? `PRR_OP_EXCEPTION_RETURN : `PRR_OP_SUB_RETURN, 1'h0, 1'h0, wt);
			issue(i ? `PRR_OP_SUB_RETURN : `PRR_OP_NO_OPERATION, i == 0, 1'h0, wt);
			chk({exc_slot_illegal_ff, pc_load_ff}, 32'h2);
		end
		issue(`PRR_OP_EXCEPTION_RETURN, 1'h0, 1'h1, wt);
		chk({exc_slot_illegal_ff, status_we_ff, pc_load_ff}, 32'h4);
	endtask

	task automatic t_user();
		int wt;
		t_rte(32'h0000_0001);
		issue(`PRR_OP_EXCEPTION_RETURN, 1'h0, 1'h0, wt);
		chk({exc_illegal_ff, pc_load_ff, status_we_ff, exc_slot_illegal_ff}, 32'h8);
	endtask

	initial begin
		clk_sys = 1'h0;
		forever #4 clk_sys = ~clk_sys;
	end

	initial begin
		forever begin
			@(posedge clk_sys);
			cycles++;
			if (cycles > 5000) begin
				n_fail++;
				report_and_stop();
			end
		end
	end

	initial begin
		reset_n = 1'h0;
		{insn_valid, insn_is_branch, insn_in_slot, insn_code, insn_pc} = '0;
		{saved_status, saved_pc, proc_ret, s_axi_wdata, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		n_fail = 0;
		compares = 0;
		pc = 32'h0000_1000;
		exp_t = 1'h0;
		for (int i = 0; i < 16; i++) begin
			exp_reg[i] = 32'h8765_4321 ^ {i[3:0], 28'h0};
		end
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'h1;
		step();
		t_regs();
		t_rot_cache_prefetch_nop();
		t_rte(32'h4000_0001);
		t_rts_slots();
		t_user();
		report_and_stop();
	end
endmodule
`default_nettype wire
